// File: core/clock_edge_detect.sv
// turns a slow clock, sampled as data, into rise and fall enable pulses
// assumes the watched clock is synchronous to core_clk_i and below half its rate
`timescale 1ns/1ps
module clock_edge_detect (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    output logic rise_o,
    output logic fall_o
);
    logic last;
    logic next_last;

    always_comb begin
        next_last = level_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            // track the pin through reset so a clock idling high shows no false edge
            last <= next_last;
        end else begin
            last <= next_last;
        end
    end

    // pulses last one core cycle per edge of the watched clock
    assign rise_o = level_i & ~last;
    assign fall_o = ~level_i & last;
endmodule

// File: core/gpio_cell_pkg.sv
// constants shared by the general-purpose pin cell and its testbench
// assumes an apb master with 32-bit data and one 125 MHz core clock
package gpio_cell_pkg;

    // ******************************************************************
    // apb map, byte addresses
    // ******************************************************************
    localparam logic [11:0] CFG_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;

    // ******************************************************************
    // configuration word fields
    // ******************************************************************
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int RX_REG_BIT = 3;
    localparam int TX_REG_BIT = 4;
    localparam int OE_REG_BIT = 5;
    localparam int RX_FALL_BIT = 6;
    localparam int TX_FALL_BIT = 7;
    localparam int OE_FALL_BIT = 8;
    localparam int TX_INV_BIT = 9;
    localparam int RX_DUAL_BIT = 10;
    localparam int TX_DUAL_BIT = 11;
    localparam int RX_RESYNC_BIT = 12;
    localparam int PULL_DOWN_BIT = 13;
    localparam int CFG_DONE_BIT = 31;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h8000_3fff;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // ******************************************************************
    // pin modes
    // ******************************************************************
    localparam logic [2:0] MODE_NONE = 3'h0;
    localparam logic [2:0] MODE_INPUT = 3'h1;
    localparam logic [2:0] MODE_OUTPUT = 3'h2;
    localparam logic [2:0] MODE_INOUT = 3'h3;
    localparam logic [2:0] MODE_CLKOUT = 3'h4;

    // ******************************************************************
    // reset values of state
    // ******************************************************************
    localparam logic BIT_RESET = 1'b0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// File: core/gpio_io_logic_cell.sv
// general-purpose pin cell: capture, launch and enable logic beside a pad buffer
// assumes pad, core data and the capture and launch clocks are synchronous to core_clk_i;
// the pad buffer itself lives outside and combines pad_o, pad_oe_o and the pulls
//
// Functional notes
// R01 - optional capture register samples the pad
// R02 - enable register switches pad buffer drive
// R03 - input mode: receive path, selectable edge
// R04 - alternate input is pad, never registered
// R05 - dual-edge input samples on both edges
// R06 - output mode: transmit path, selectable edge
// R07 - optional inversion of driven value
// R08 - dual-edge output launches two bits per period
// R09 - bidirectional mode enables all three paths
// R10 - capture clock feeds rx, launch clock feeds tx/oe
// R11 - each register has its own edge
// R12 - rx and tx registering chosen independently
// R13 - clock-output mode drives clkout_i out
// R14 - while configuring: tristate with pull-up
// R15 - unused pin: pull-up, or pull-down if chosen
// R16 - bit zero rising edge, bit one falling
// R17 - resync delays falling sample half period
// R18 - enable low tristates, high drives tx value
// R19 - settings frozen once configuration completes
`timescale 1ns/1ps
module gpio_io_logic_cell (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_clock_i,
    input wire logic launch_clock_i,
    input wire logic tx_bit_rise_i,
    input wire logic tx_bit_fall_i,
    input wire logic oe_i,
    input wire logic clkout_i,
    output logic rx_bit_rise_o,
    output logic rx_bit_fall_o,
    output logic alternate_input_o,
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_o,
    output logic pull_up_o,
    output logic pull_down_o
);
    // ******************************************************************
    // apb slave and configuration word
    // ******************************************************************
    logic [31:0] cfg;
    logic [31:0] next_cfg;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [31:0] status;
    logic setup;
    logic access;
    logic hit_cfg;
    logic hit_status;
    logic cfg_write;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit_cfg = paddr == gpio_cell_pkg::CFG_ADDR;
    assign hit_status = paddr == gpio_cell_pkg::STATUS_ADDR;
    assign cfg_write = access & pwrite & hit_cfg;
    assign pready = 1'b1;

    always_comb begin
        next_cfg = cfg;
        next_prdata = prdata;
        next_pslverr = pslverr;
        // once done is set, further writes are dropped and flagged [R19]
        if (cfg_write && !cfg[gpio_cell_pkg::CFG_DONE_BIT]) begin
            next_cfg = pwdata & gpio_cell_pkg::CFG_WRITE_MASK;
        end
        if (setup) begin
            next_prdata = hit_cfg ? cfg : (hit_status ? status : gpio_cell_pkg::WORD_ZERO);
            next_pslverr = ~(hit_cfg | hit_status) | (pwrite & hit_status)
                | (pwrite & hit_cfg & cfg[gpio_cell_pkg::CFG_DONE_BIT]);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg <= gpio_cell_pkg::CFG_RESET;
            prdata <= gpio_cell_pkg::WORD_ZERO;
            pslverr <= gpio_cell_pkg::BIT_RESET;
        end else begin
            cfg <= next_cfg;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    logic [2:0] mode;
    logic configuring;
    logic rx_active;
    logic tx_active;
    assign mode = cfg[gpio_cell_pkg::MODE_LSB +: gpio_cell_pkg::MODE_W];
    assign configuring = ~cfg[gpio_cell_pkg::CFG_DONE_BIT];
    // [R03] [R06] [R09]
    assign rx_active = ~configuring
        & (mode == gpio_cell_pkg::MODE_INPUT || mode == gpio_cell_pkg::MODE_INOUT);
    assign tx_active = ~configuring
        & (mode == gpio_cell_pkg::MODE_OUTPUT || mode == gpio_cell_pkg::MODE_INOUT);

    // ******************************************************************
    // clock edges as enables
    // ******************************************************************
    logic cap_rise;
    logic cap_fall;
    logic lau_rise;
    logic lau_fall;

    clock_edge_detect u_capture_edges (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(capture_clock_i),
        .rise_o(cap_rise),
        .fall_o(cap_fall)
    );

    clock_edge_detect u_launch_edges (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .level_i(launch_clock_i),
        .rise_o(lau_rise),
        .fall_o(lau_fall)
    );

    logic rx_edge;
    logic tx_edge;
    logic oe_edge;
    // each register picks its own edge [R10] [R11]
    assign rx_edge = cfg[gpio_cell_pkg::RX_FALL_BIT] ? cap_fall : cap_rise;
    assign tx_edge = cfg[gpio_cell_pkg::TX_FALL_BIT] ? lau_fall : lau_rise;
    assign oe_edge = cfg[gpio_cell_pkg::OE_FALL_BIT] ? lau_fall : lau_rise;

    // ******************************************************************
    // receive path
    // ******************************************************************
    logic fall_hold;
    logic next_fall_hold;
    logic next_rx_rise;
    logic next_rx_fall;

    // no register on this path at all [R04]
    assign alternate_input_o = pad_i;

    always_comb begin
        next_rx_rise = rx_bit_rise_o;
        next_rx_fall = rx_bit_fall_o;
        next_fall_hold = fall_hold;
        if (!rx_active) begin
            next_rx_rise = 1'b0;
            next_rx_fall = 1'b0;
        end else if (!cfg[gpio_cell_pkg::RX_REG_BIT]) begin
            next_rx_rise = pad_i; // [R12]
        end else if (!cfg[gpio_cell_pkg::RX_DUAL_BIT]) begin
            if (rx_edge) begin
                next_rx_rise = pad_i; // [R01] [R03]
            end
        end else begin
            if (cap_rise) begin
                next_rx_rise = pad_i; // [R05] [R16]
            end
            if (cfg[gpio_cell_pkg::RX_RESYNC_BIT]) begin
                // falling sample waits for the next rising edge [R17]
                if (cap_fall) begin
                    next_fall_hold = pad_i;
                end
                if (cap_rise) begin
                    next_rx_fall = fall_hold;
                end
            end else if (cap_fall) begin
                next_rx_fall = pad_i; // [R05] [R16]
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_bit_rise_o <= gpio_cell_pkg::BIT_RESET;
            rx_bit_fall_o <= gpio_cell_pkg::BIT_RESET;
            fall_hold <= gpio_cell_pkg::BIT_RESET;
        end else begin
            rx_bit_rise_o <= next_rx_rise;
            rx_bit_fall_o <= next_rx_fall;
            fall_hold <= next_fall_hold;
        end
    end

    // ******************************************************************
    // transmit and enable paths
    // ******************************************************************
    logic tx_q;
    logic oe_q;
    logic next_tx_q;
    logic next_oe_q;
    logic next_pad_o;
    logic next_pad_oe;

    always_comb begin
        next_tx_q = tx_q;
        next_oe_q = oe_q;
        if (!cfg[gpio_cell_pkg::TX_REG_BIT]) begin
            next_tx_q = tx_bit_rise_i; // [R12]
        end else if (cfg[gpio_cell_pkg::TX_DUAL_BIT]) begin
            // two bits per launch period [R08] [R16]
            if (lau_rise) begin
                next_tx_q = tx_bit_rise_i;
            end else if (lau_fall) begin
                next_tx_q = tx_bit_fall_i;
            end
        end else if (tx_edge) begin
            next_tx_q = tx_bit_rise_i; // [R06]
        end
        if (!cfg[gpio_cell_pkg::OE_REG_BIT] || oe_edge) begin
            next_oe_q = oe_i; // [R02] [R10]
        end
        next_pad_o = 1'b0;
        next_pad_oe = 1'b0;
        if (mode == gpio_cell_pkg::MODE_CLKOUT && !configuring) begin
            next_pad_o = clkout_i; // [R13]
            next_pad_oe = 1'b1;
        end else if (tx_active) begin
            next_pad_o = next_tx_q ^ cfg[gpio_cell_pkg::TX_INV_BIT]; // [R07]
            // enable low leaves the pad floating [R18]
            next_pad_oe = (mode == gpio_cell_pkg::MODE_INOUT) ? next_oe_q : 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tx_q <= gpio_cell_pkg::BIT_RESET;
            oe_q <= gpio_cell_pkg::BIT_RESET;
            pad_o <= gpio_cell_pkg::BIT_RESET;
            pad_oe_o <= gpio_cell_pkg::BIT_RESET;
        end else begin
            tx_q <= next_tx_q;
            oe_q <= next_oe_q;
            pad_o <= next_pad_o;
            pad_oe_o <= next_pad_oe; // [R14]
        end
    end

    // ******************************************************************
    // weak pulls
    // ******************************************************************
    // pull-up while configuring; unused pins follow the pull-down choice [R14] [R15]
    assign pull_up_o = configuring
        | (mode == gpio_cell_pkg::MODE_NONE & ~cfg[gpio_cell_pkg::PULL_DOWN_BIT]);
    assign pull_down_o = ~configuring
        & (mode == gpio_cell_pkg::MODE_NONE) & cfg[gpio_cell_pkg::PULL_DOWN_BIT];

    assign status = {26'h000_0000, configuring, pad_o, pad_oe_o, rx_bit_fall_o,
        rx_bit_rise_o, pad_i};

    // ******************************************************************
    // assertions
    // ******************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_cfg_tristate: assert property (configuring |-> pull_up_o && !pull_down_o ##1 !pad_oe_o) // [R14]
        else $error("pad not floating with pull-up while configuring");
    a_unused_pull: assert property (!configuring && mode == gpio_cell_pkg::MODE_NONE |->
        pull_down_o == cfg[gpio_cell_pkg::PULL_DOWN_BIT]
        && pull_up_o == !cfg[gpio_cell_pkg::PULL_DOWN_BIT]) // [R15]
        else $error("unused pin pull wrong");
    a_alt_direct: assert property ($changed(pad_i) |-> $changed(alternate_input_o)) // [R04]
        else $error("alternate input lags pad");
    a_rx_bypass: assert property (rx_active && !cfg[gpio_cell_pkg::RX_REG_BIT] |=>
        rx_bit_rise_o == $past(pad_i)) // [R12]
        else $error("unregistered receive does not follow pad");
    a_rx_single: assert property (rx_active && cfg[gpio_cell_pkg::RX_REG_BIT]
        && !cfg[gpio_cell_pkg::RX_DUAL_BIT] && !rx_edge ##1 rx_active |->
        $stable(rx_bit_rise_o)) // [R01]
        else $error("capture register moved off its edge");
    a_rx_dual_rise: assert property (rx_active && cfg[gpio_cell_pkg::RX_REG_BIT]
        && cfg[gpio_cell_pkg::RX_DUAL_BIT] && cap_rise |=>
        rx_bit_rise_o == $past(pad_i)) // [R05]
        else $error("rising sample missing on bit zero");
    a_rx_dual_fall: assert property (rx_active && cfg[gpio_cell_pkg::RX_REG_BIT]
        && cfg[gpio_cell_pkg::RX_DUAL_BIT] && !cfg[gpio_cell_pkg::RX_RESYNC_BIT]
        && cap_fall |=> rx_bit_fall_o == $past(pad_i)) // [R16]
        else $error("falling sample missing on bit one");
    a_rx_resync: assert property (rx_active && cfg[gpio_cell_pkg::RX_REG_BIT]
        && cfg[gpio_cell_pkg::RX_DUAL_BIT] && cfg[gpio_cell_pkg::RX_RESYNC_BIT]
        && cap_rise |=> rx_bit_fall_o == $past(fall_hold)) // [R17]
        else $error("resync bit one not moved on rising edge");
    a_tx_dual_fall: assert property (tx_active && cfg[gpio_cell_pkg::TX_REG_BIT]
        && cfg[gpio_cell_pkg::TX_DUAL_BIT] && lau_fall |=>
        pad_o == ($past(tx_bit_fall_i) ^ cfg[gpio_cell_pkg::TX_INV_BIT])) // [R08]
        else $error("bit one not launched on falling edge");
    a_tx_invert: assert property (tx_active && !cfg[gpio_cell_pkg::TX_REG_BIT] |=>
        pad_o == ($past(tx_bit_rise_i) ^ cfg[gpio_cell_pkg::TX_INV_BIT])) // [R07]
        else $error("driven value inversion wrong");
    a_oe_edge: assert property (mode == gpio_cell_pkg::MODE_INOUT && !configuring
        && cfg[gpio_cell_pkg::OE_REG_BIT] && oe_edge |=> pad_oe_o == $past(oe_i)) // [R02]
        else $error("enable register not taken on launch edge");
    a_clk_out: assert property (!configuring && mode == gpio_cell_pkg::MODE_CLKOUT |=>
        pad_oe_o && pad_o == $past(clkout_i)) // [R13]
        else $error("clock output not driven");
    a_cfg_locked: assert property (!configuring && cfg_write |=> $stable(cfg)) // [R19]
        else $error("configuration changed after done");

    c_rx_resync: cover property (rx_active && cfg[gpio_cell_pkg::RX_RESYNC_BIT] && cap_rise);
    c_tx_dual: cover property (tx_active && cfg[gpio_cell_pkg::TX_DUAL_BIT] && lau_fall);
    c_oe_toggle: cover property (mode == gpio_cell_pkg::MODE_INOUT && $rose(pad_oe_o));
endmodule

// File: testbench/gpio_io_logic_cell_tb.sv
// self-checking bench of the pin cell: apb set-up, then one task per scenario
// assumes the board model on the pad and slow capture and launch clocks as data
`timescale 1ns/1ps
module gpio_io_logic_cell_tb;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cap = 1'b0;
    logic lau = 1'b0;
    logic tx_rise = 1'b0;
    logic tx_fall = 1'b0;
    logic oe = 1'b0;
    logic clkout = 1'b0;
    logic bd = 1'b1;
    logic bv = 1'b0;
    logic rx_rise, rx_fall, alt_in, pad_i, pad_o, pad_oe, pull_up, pull_down;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    gpio_io_logic_cell i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_clock_i(cap), .launch_clock_i(lau),
        .tx_bit_rise_i(tx_rise), .tx_bit_fall_i(tx_fall), .oe_i(oe), .clkout_i(clkout),
        .rx_bit_rise_o(rx_rise), .rx_bit_fall_o(rx_fall), .alternate_input_o(alt_in),
        .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe), .pull_up_o(pull_up),
        .pull_down_o(pull_down));

    pad_board_model i_board (.core_clk_i(core_clk_i), .pad_o(pad_o), .pad_oe_o(pad_oe),
        .pull_up_o(pull_up), .pull_down_o(pull_down), .board_drive_i(bd),
        .board_value_i(bv), .pad_i(pad_i));

    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end

    // ********************************************************************
    // shared tasks
    // ********************************************************************
    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    function automatic logic [31:0] on(input int b);
        return 32'h0000_0001 << b;
    endfunction

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        @(posedge core_clk_i);
        while (pready !== 1'b1) begin
            @(posedge core_clk_i);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic cap0);
        rst_n_i <= 1'b0;
        cap <= cap0;
        {lau, tx_rise, tx_fall, oe, clkout, bv} <= 6'h00;
        bd <= 1'b1;
        step(4);
        rst_n_i <= 1'b1;
    endtask

    // ********************************************************************
    // scenarios
    // ********************************************************************
    task automatic t_defaults();
        do_reset(1'b0);
        step(1);
        chk_bit("pull_up_o", 1'b1, pull_up);
        chk_bit("pull_down_o", 1'b0, pull_down);
        chk_bit("pad_oe_o", 1'b0, pad_oe);
        apb(1'b0, gpio_cell_pkg::CFG_ADDR, 32'h0000_0000);
        chk_word("cfg reset", gpio_cell_pkg::CFG_RESET, rd);
        apb(1'b0, gpio_cell_pkg::STATUS_ADDR, 32'h0000_0000);
        chk_bit("configuring", 1'b1, rd[5]);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk_bit("unmapped err", 1'b1, err);
        apb(1'b1, gpio_cell_pkg::STATUS_ADDR, 32'h0000_ffff);
        chk_bit("status write err", 1'b1, err);
    endtask

    // cap idles at fall so the first change is the selected edge
    task automatic t_input(input logic fall);
        do_reset(fall);
        apb(1'b1, gpio_cell_pkg::CFG_ADDR, 32'(gpio_cell_pkg::MODE_INPUT)
            | on(gpio_cell_pkg::RX_REG_BIT) | (fall ? on(gpio_cell_pkg::RX_FALL_BIT) : 0)
            | on(gpio_cell_pkg::CFG_DONE_BIT));
        bv <= 1'b1;
        step(3);
        cap <= ~fall;
        step(3);
        chk_bit("rx sampled", 1'b1, rx_rise);
        chk_bit("no drive in input", 1'b0, pad_oe);
        bv <= 1'b0;
        step(3);
        chk_bit("alternate input", 1'b0, alt_in);
        chk_bit("rx held", 1'b1, rx_rise);
        cap <= fall;
        step(3);
        chk_bit("other edge ignored", 1'b1, rx_rise);
        cap <= ~fall;
        step(3);
        chk_bit("rx resampled", 1'b0, rx_rise);
    endtask

    // in resync the falling sample reaches the core only at the next rising edge
    task automatic t_dual_rx(input logic resync);
        do_reset(1'b0);
        apb(1'b1, gpio_cell_pkg::CFG_ADDR, 32'(gpio_cell_pkg::MODE_INPUT)
            | on(gpio_cell_pkg::RX_REG_BIT) | on(gpio_cell_pkg::RX_DUAL_BIT)
            | (resync ? on(gpio_cell_pkg::RX_RESYNC_BIT) : 0)
            | on(gpio_cell_pkg::CFG_DONE_BIT));
        bv <= 1'b1;
        step(2);
        cap <= 1'b1;
        step(3);
        bv <= 1'b0;
        step(2);
        cap <= 1'b0;
        step(3);
        chk_bit("rise stream", 1'b1, rx_rise);
        chk_bit("fall stream", 1'b0, rx_fall);
        cap <= 1'b1;
        step(3);
        bv <= 1'b1;
        step(2);
        cap <= 1'b0;
        step(3);
        chk_bit("rise stream", 1'b0, rx_rise);
        chk_bit("fall stream", !resync, rx_fall);
        cap <= 1'b1;
        step(3);
        chk_bit("rise stream", 1'b1, rx_rise);
        chk_bit("fall stream at rise", 1'b1, rx_fall);
    endtask

    // dual launches bit zero on rise and bit one on fall; single uses the fall edge here
    task automatic t_tx_edges(input logic dual);
        do_reset(1'b0);
        apb(1'b1, gpio_cell_pkg::CFG_ADDR, 32'(gpio_cell_pkg::MODE_OUTPUT)
            | on(gpio_cell_pkg::TX_REG_BIT) | on(gpio_cell_pkg::CFG_DONE_BIT)
            | (dual ? on(gpio_cell_pkg::TX_DUAL_BIT) : on(gpio_cell_pkg::TX_FALL_BIT)));
        tx_rise <= 1'b1;
        step(3);
        chk_bit("tx before launch", 1'b0, pad_o);
        lau <= 1'b1;
        step(3);
        chk_bit("tx after rise", dual, pad_o);
        lau <= 1'b0;
        step(3);
        chk_bit("tx after fall", !dual, pad_o);
    endtask

    task automatic t_output_inv();
        do_reset(1'b0);
        apb(1'b1, gpio_cell_pkg::CFG_ADDR, 32'(gpio_cell_pkg::MODE_OUTPUT)
            | on(gpio_cell_pkg::TX_INV_BIT) | on(gpio_cell_pkg::CFG_DONE_BIT));
        tx_rise <= 1'b1;
        step(3);
        chk_bit("inverted out", 1'b0, pad_o);
        chk_bit("output drives", 1'b1, pad_oe);
        tx_rise <= 1'b0;
        step(3);
        chk_bit("inverted out", 1'b1, pad_o);
    endtask

    // rx bypassed, tx on rising launch edge, enable on falling launch edge
    task automatic t_inout();
        do_reset(1'b0);
        apb(1'b1, gpio_cell_pkg::CFG_ADDR, 32'(gpio_cell_pkg::MODE_INOUT)
            | on(gpio_cell_pkg::TX_REG_BIT) | on(gpio_cell_pkg::OE_REG_BIT)
            | on(gpio_cell_pkg::OE_FALL_BIT) | on(gpio_cell_pkg::CFG_DONE_BIT));
        tx_rise <= 1'b1;
        oe <= 1'b1;
        step(3);
        chk_bit("oe waits edge", 1'b0, pad_oe);
        chk_bit("tx waits edge", 1'b0, pad_o);
        lau <= 1'b1;
        step(3);
        chk_bit("tx on rise", 1'b1, pad_o);
        chk_bit("oe not on rise", 1'b0, pad_oe);
        lau <= 1'b0;
        step(3);
        chk_bit("oe on fall", 1'b1, pad_oe);
        chk_bit("rx bypass", 1'b1, rx_rise);
    endtask

    task automatic t_clkout();
        do_reset(1'b0);
        apb(1'b1, gpio_cell_pkg::CFG_ADDR, 32'(gpio_cell_pkg::MODE_CLKOUT)
            | on(gpio_cell_pkg::CFG_DONE_BIT));
        clkout <= 1'b1;
        step(3);
        chk_bit("clock out high", 1'b1, pad_o);
        chk_bit("clock out drives", 1'b1, pad_oe);
        clkout <= 1'b0;
        step(3);
        chk_bit("clock out low", 1'b0, pad_o);
    endtask

    task automatic t_pull_frozen();
        logic [31:0] w;
        do_reset(1'b0);
        w = 32'(gpio_cell_pkg::MODE_NONE) | on(gpio_cell_pkg::PULL_DOWN_BIT);
        // board lets go so the pad settles to whichever weak pull is on
        bd <= 1'b0;
        apb(1'b1, gpio_cell_pkg::CFG_ADDR, w);
        step(2);
        chk_bit("pull up while configuring", 1'b1, pull_up);
        chk_bit("pad pulled up", 1'b1, alt_in);
        apb(1'b1, gpio_cell_pkg::CFG_ADDR, w | on(gpio_cell_pkg::CFG_DONE_BIT));
        step(2);
        chk_bit("unused pull down", 1'b1, pull_down);
        chk_bit("pad pulled down", 1'b0, alt_in);
        chk_bit("unused no pull up", 1'b0, pull_up);
        chk_bit("unused floats", 1'b0, pad_oe);
        apb(1'b1, gpio_cell_pkg::CFG_ADDR, 32'h0000_0000);
        chk_bit("late write err", 1'b1, err);
        apb(1'b0, gpio_cell_pkg::CFG_ADDR, 32'h0000_0000);
        chk_word("cfg frozen", w | on(gpio_cell_pkg::CFG_DONE_BIT), rd);
    endtask

    initial begin
        do_reset(1'b0);
        t_defaults();
        t_input(1'b0);
        t_input(1'b1);
        t_dual_rx(1'b0);
        t_dual_rx(1'b1);
        t_output_inv();
        t_tx_edges(1'b1);
        t_tx_edges(1'b0);
        t_inout();
        t_clkout();
        t_pull_frozen();
        finish_test();
    end
endmodule

// File: testbench/pad_board_model.sv
// board-side model of the signal wired to the pin of the cell
// assumes pad_oe_o high means the cell drives and the board only listens
`timescale 1ns/1ps
module pad_board_model (
    input wire logic core_clk_i,
    input wire logic pad_o,
    input wire logic pad_oe_o,
    input wire logic pull_up_o,
    input wire logic pull_down_o,
    input wire logic board_drive_i,
    input wire logic board_value_i,
    output logic pad_i
);
    logic wander = 1'b0;

    // a floating line with no pull must not look like a stable old value
    always @(posedge core_clk_i) begin
        wander <= ~wander;
    end

    always_comb begin
        if (pad_oe_o) begin
            pad_i = pad_o;
        end else if (board_drive_i) begin
            pad_i = board_value_i;
        end else if (pull_up_o) begin
            pad_i = 1'b1;
        end else if (pull_down_o) begin
            pad_i = 1'b0;
        end else begin
            pad_i = wander;
        end
    end
endmodule
